// >>> verilog/cad_map.svh
`ifndef CAD_MAP_SVH
`define CAD_MAP_SVH

// fetch
`define CAD_RESET_PC      16'h0000
`define CAD_MUL_CYCLES    2

// data space regions
`define CAD_IO_TOP        16'h003F
`define CAD_IOBIT_TOP     16'h001F
`define CAD_EXTIO_LO      16'h0040
`define CAD_EXTIO_HI      16'h0FFF
`define CAD_NVM_LO        16'h1000
`define CAD_MEM_LO        16'h1800
`define CAD_MEM_HI        16'h7FFF
`define CAD_FLASH_LO      16'h8000

// register file layout
`define CAD_PTR_X         5'h1A
`define CAD_PTR_Y         5'h1C
`define CAD_PTR_Z         5'h1E
`define CAD_PROD_LO       5'h00
`define CAD_PROD_HI       5'h01
`define CAD_FLAGS_RESET   8'h00

// condition flag bit positions
`define CAD_FLAG_C        0
`define CAD_FLAG_Z        1
`define CAD_FLAG_N        2
`define CAD_FLAG_V        3
`define CAD_FLAG_S        4
`define CAD_FLAG_H        5

`endif

// >>> verilog/cad_pkg.sv
package cad_pkg;

    typedef enum logic [4:0] {
        CAD_ALU_NONE, CAD_ALU_ADD, CAD_ALU_ADC, CAD_ALU_SUB, CAD_ALU_SBC, CAD_ALU_AND,
        CAD_ALU_OR, CAD_ALU_EOR, CAD_ALU_MOV, CAD_ALU_COM, CAD_ALU_NEG, CAD_ALU_INC,
        CAD_ALU_DEC, CAD_ALU_LSR, CAD_ALU_ROR, CAD_ALU_ASR, CAD_ALU_SWAP, CAD_ALU_ADIW,
        CAD_ALU_SBIW
    } cad_aluop_t;

    typedef enum logic [2:0] {
        CAD_MUL_NONE, CAD_MUL_UU, CAD_MUL_SS, CAD_MUL_SU, CAD_MUL_FUU, CAD_MUL_FSS, CAD_MUL_FSU
    } cad_mulop_t;

    typedef enum logic [3:0] {
        CAD_MEM_NONE, CAD_MEM_LOAD, CAD_MEM_STORE, CAD_MEM_IN, CAD_MEM_OUT,
        CAD_MEM_BSET, CAD_MEM_BCLR, CAD_MEM_SKIPSET, CAD_MEM_SKIPCLR, CAD_MEM_LPM
    } cad_memop_t;

    typedef enum logic [1:0] {CAD_PTR_X, CAD_PTR_Y, CAD_PTR_Z} cad_ptr_t;
    typedef enum logic [1:0] {CAD_PM_PLAIN, CAD_PM_POSTINC, CAD_PM_PREDEC} cad_ptrmode_t;
    typedef enum logic [2:0] {CAD_RG_IO, CAD_RG_EXTIO, CAD_RG_NVM, CAD_RG_SRAM, CAD_RG_FLASH} cad_region_t;
    typedef enum logic [1:0] {CAD_ST_EXEC, CAD_ST_MUL2, CAD_ST_LPM2} cad_state_t;

endpackage : cad_pkg

// >>> verilog/cad_core.sv
`timescale 1ns/1ps
`include "cad_map.svh"
//////////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////////
module cad_core (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    // program memory bus
    output logic [15:0]               progAddr,
    input  wire logic [15:0]          progRdData,
    output logic [15:0]               instrWord,
    output logic                      instrValid,
    input  wire logic                 pcLoad,
    input  wire logic [15:0]          pcTarget,
    // decoded operation
    input  wire logic                 opValid,
    input  wire cad_pkg::cad_aluop_t  aluOp,
    input  wire cad_pkg::cad_mulop_t  mulOp,
    input  wire cad_pkg::cad_memop_t  memOp,
    input  wire logic [4:0]           dstSel,
    input  wire logic [4:0]           srcSel,
    input  wire logic [7:0]           immData,
    input  wire logic                 useImm,
    input  wire cad_pkg::cad_ptr_t    ptrSel,
    input  wire cad_pkg::cad_ptrmode_t ptrMode,
    input  wire logic [5:0]           ptrDisp,
    input  wire logic                 useDirect,
    input  wire logic [15:0]          directAddr,
    input  wire logic [5:0]           ioAddr,
    input  wire logic [2:0]           bitIdx,
    input  wire logic                 wideAccess,
    // data memory bus
    output logic [15:0]               dataAddr,
    output cad_pkg::cad_region_t      dataRegion,
    output logic                      dataRdEn,
    output logic                      dataWrEn,
    output logic                      dataWide,
    output logic [15:0]               dataWrData,
    input  wire logic [15:0]          dataRdData,
    output logic                      dataBitEn,
    output logic                      dataBitVal,
    // status
    output logic [7:0]                flags,
    output logic                      busy,
    output logic                      skipNext,
    output logic                      ioRefused
);
    import cad_pkg::*;

    logic [7:0]  gpr [32];
    logic [15:0] pc_reg;
    logic [15:0] instr_reg;
    logic        instrValid_reg;
    logic [7:0]  flags_reg;
    cad_state_t  state_reg;
    logic [7:0]  mulA_reg, mulB_reg;
    cad_mulop_t  mulOp_reg;
    logic [15:0] lpmAddr_reg;
    logic [4:0]  lpmDst_reg;
    logic        take;
    logic [7:0]  opA, opB, aluRes;
    logic [15:0] pairVal, pairRes;
    logic [8:0]  sum9;
    logic [7:0]  flags_next;
    logic        aluWe, aluWide;
    logic [4:0]  ptrIdx;
    logic [15:0] ptrVal, ptrNew, effAddr;
    logic        ptrWe, isIoOp, isBitOp;
    logic [17:0] mulProd;
    logic [15:0] mulRes;

    assign take       = clkEn && opValid && (state_reg == CAD_ST_EXEC);
    assign busy       = (state_reg != CAD_ST_EXEC);
    assign flags      = flags_reg;
    assign instrWord  = instr_reg;
    assign instrValid = instrValid_reg;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // fetch: program bus never shares with data bus; it carries the LPM byte address halved in CAD_ST_LPM2 and otherwise the PC
    assign progAddr = (state_reg == CAD_ST_LPM2) ? {1'b0, lpmAddr_reg[15:1]} : pc_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_reg         <= `CAD_RESET_PC;
            instr_reg      <= 16'h0000;
            instrValid_reg <= 1'b0;
        end else if (clkEn && state_reg == CAD_ST_EXEC) begin
            // prefetch overlaps execution of the word already held
            instr_reg      <= progRdData;
            instrValid_reg <= !pcLoad;
            pc_reg         <= pcLoad ? pcTarget : pc_reg + 16'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // operand select and ALU
    assign opA     = gpr[dstSel];
    assign opB     = useImm ? immData : gpr[srcSel];
    assign pairVal = {gpr[{dstSel[4:1], 1'b1}], gpr[{dstSel[4:1], 1'b0}]};

    always_comb begin
        aluRes     = opA;
        pairRes    = pairVal;
        sum9       = 9'h000;
        flags_next = flags_reg;
        aluWe      = 1'b1;
        aluWide    = 1'b0;
        unique case (aluOp)
            CAD_ALU_ADD, CAD_ALU_ADC: begin
                sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, aluOp == CAD_ALU_ADC && flags_reg[`CAD_FLAG_C]};
                aluRes = sum9[7:0];
                flags_next[`CAD_FLAG_C] = sum9[8];
                flags_next[`CAD_FLAG_H] = (opA[3] & opB[3]) | (opB[3] & ~aluRes[3]) | (~aluRes[3] & opA[3]);
                flags_next[`CAD_FLAG_V] = (opA[7] & opB[7] & ~aluRes[7]) | (~opA[7] & ~opB[7] & aluRes[7]);
            end
            CAD_ALU_SUB, CAD_ALU_SBC, CAD_ALU_NEG: begin
                if (aluOp == CAD_ALU_NEG)
                    sum9 = 9'h000 - {1'b0, opA};
                else
                    sum9 = {1'b0, opA} - {1'b0, opB} - {8'h00, aluOp == CAD_ALU_SBC && flags_reg[`CAD_FLAG_C]};
                aluRes = sum9[7:0];
                flags_next[`CAD_FLAG_C] = sum9[8];
                flags_next[`CAD_FLAG_H] = (aluOp == CAD_ALU_NEG) ? (aluRes[3] | opA[3]) :
                                          ((~opA[3] & opB[3]) | (opB[3] & aluRes[3]) | (aluRes[3] & ~opA[3]));
                flags_next[`CAD_FLAG_V] = (aluOp == CAD_ALU_NEG) ? (aluRes == 8'h80) :
                                          ((opA[7] & ~opB[7] & ~aluRes[7]) | (~opA[7] & opB[7] & aluRes[7]));
            end
            CAD_ALU_AND, CAD_ALU_OR, CAD_ALU_EOR: begin
                aluRes = (aluOp == CAD_ALU_AND) ? (opA & opB) : (aluOp == CAD_ALU_OR) ? (opA | opB) : (opA ^ opB);
                flags_next[`CAD_FLAG_V] = 1'b0;
            end
            CAD_ALU_COM: begin
                aluRes = ~opA;
                flags_next[`CAD_FLAG_C] = 1'b1;
                flags_next[`CAD_FLAG_V] = 1'b0;
            end
            CAD_ALU_INC, CAD_ALU_DEC: begin
                aluRes = (aluOp == CAD_ALU_INC) ? opA + 8'h01 : opA - 8'h01;
                flags_next[`CAD_FLAG_V] = (aluOp == CAD_ALU_INC) ? (aluRes == 8'h80) : (aluRes == 8'h7F);
            end
            CAD_ALU_LSR, CAD_ALU_ROR, CAD_ALU_ASR: begin
                aluRes = {(aluOp == CAD_ALU_LSR) ? 1'b0 : (aluOp == CAD_ALU_ROR) ? flags_reg[`CAD_FLAG_C] : opA[7],
                          opA[7:1]};
                flags_next[`CAD_FLAG_C] = opA[0];
                flags_next[`CAD_FLAG_V] = aluRes[7] ^ opA[0];
            end
            CAD_ALU_MOV:  aluRes = opB;
            CAD_ALU_SWAP: aluRes = {opA[3:0], opA[7:4]};
            CAD_ALU_ADIW, CAD_ALU_SBIW: begin
                // 16-bit immediate arithmetic on a register pair
                aluWide = 1'b1;
                pairRes = (aluOp == CAD_ALU_ADIW) ? pairVal + {10'h000, immData[5:0]}
                                                  : pairVal - {10'h000, immData[5:0]};
                flags_next[`CAD_FLAG_C] = (aluOp == CAD_ALU_ADIW) ? (~pairRes[15] & pairVal[15])
                                                                  : (pairRes[15] & ~pairVal[15]);
                flags_next[`CAD_FLAG_V] = (aluOp == CAD_ALU_ADIW) ? (~pairVal[15] & pairRes[15])
                                                                  : (pairVal[15] & ~pairRes[15]);
            end
            default: aluWe = 1'b0;
        endcase
        // move and swap leave the flags alone
        if (aluOp != CAD_ALU_MOV && aluOp != CAD_ALU_SWAP && aluWe) begin
            flags_next[`CAD_FLAG_Z] = aluWide ? (pairRes == 16'h0000) : (aluRes == 8'h00);
            flags_next[`CAD_FLAG_N] = aluWide ? pairRes[15] : aluRes[7];
            flags_next[`CAD_FLAG_S] = flags_next[`CAD_FLAG_N] ^ flags_next[`CAD_FLAG_V];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // multiplier, product formed from latched operands in the second cycle
    always_comb begin
        logic sa, sb;
        sa = (mulOp_reg == CAD_MUL_SS) || (mulOp_reg == CAD_MUL_SU) ||
             (mulOp_reg == CAD_MUL_FSS) || (mulOp_reg == CAD_MUL_FSU);
        sb = (mulOp_reg == CAD_MUL_SS) || (mulOp_reg == CAD_MUL_FSS);
        mulProd = $signed({{10{sa & mulA_reg[7]}}, mulA_reg}) * $signed({{10{sb & mulB_reg[7]}}, mulB_reg});
        // fractional variants keep the binary point aligned
        mulRes  = (mulOp_reg >= CAD_MUL_FUU) ? {mulProd[14:0], 1'b0} : mulProd[15:0];
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // data address generation and region decode
    always_comb begin
        unique case (ptrSel)
            CAD_PTR_X: ptrIdx = `CAD_PTR_X;
            CAD_PTR_Y: ptrIdx = `CAD_PTR_Y;
            default:   ptrIdx = `CAD_PTR_Z;
        endcase
    end
    assign ptrVal  = {gpr[ptrIdx + 5'h01], gpr[ptrIdx]};
    assign ptrNew  = (ptrMode == CAD_PM_PREDEC) ? ptrVal - 16'h0001 : ptrVal + 16'h0001;
    assign isIoOp  = (memOp == CAD_MEM_IN) || (memOp == CAD_MEM_OUT) || isBitOp;
    assign isBitOp = (memOp == CAD_MEM_BSET) || (memOp == CAD_MEM_BCLR) ||
                     (memOp == CAD_MEM_SKIPSET) || (memOp == CAD_MEM_SKIPCLR);
    assign effAddr = isIoOp ? {10'h000, ioAddr} : useDirect ? directAddr :
                     (ptrMode == CAD_PM_PREDEC) ? ptrNew : ptrVal + {10'h000, ptrDisp};
    assign ptrWe   = take && !useDirect && (ptrMode != CAD_PM_PLAIN) &&
                     (memOp == CAD_MEM_LOAD || memOp == CAD_MEM_STORE);

    always_comb begin
        if (dataAddr <= `CAD_IO_TOP)
            dataRegion = CAD_RG_IO;
        else if (dataAddr <= `CAD_EXTIO_HI)
            dataRegion = CAD_RG_EXTIO;
        else if (dataAddr < `CAD_MEM_LO)
            dataRegion = CAD_RG_NVM;
        else if (dataAddr <= `CAD_MEM_HI)
            dataRegion = CAD_RG_SRAM;
        else
            dataRegion = CAD_RG_FLASH;
    end

    // bit operations beyond the lowest 32 addresses are refused, not widened
    assign ioRefused  = take && isBitOp && (effAddr > `CAD_IOBIT_TOP);
    assign dataAddr   = effAddr;
    assign dataRdEn   = take && (memOp == CAD_MEM_LOAD || memOp == CAD_MEM_IN ||
                                 ((memOp == CAD_MEM_SKIPSET || memOp == CAD_MEM_SKIPCLR) && !ioRefused));
    assign dataWrEn   = take && (memOp == CAD_MEM_STORE || memOp == CAD_MEM_OUT);
    assign dataWide   = take && wideAccess && (memOp == CAD_MEM_LOAD || memOp == CAD_MEM_STORE);
    assign dataWrData = {gpr[{dstSel[4:1], 1'b1}], dataWide ? gpr[{dstSel[4:1], 1'b0}] : opA};
    assign dataBitEn  = take && (memOp == CAD_MEM_BSET || memOp == CAD_MEM_BCLR) && !ioRefused;
    assign dataBitVal = (memOp == CAD_MEM_BSET);
    assign skipNext   = dataRdEn && (memOp == CAD_MEM_SKIPSET || memOp == CAD_MEM_SKIPCLR) &&
                        (dataRdData[bitIdx] == (memOp == CAD_MEM_SKIPSET));

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // sequencing for two-cycle operations
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= CAD_ST_EXEC;
            mulA_reg    <= 8'h00;
            mulB_reg    <= 8'h00;
            mulOp_reg   <= CAD_MUL_NONE;
            lpmAddr_reg <= 16'h0000;
            lpmDst_reg  <= 5'h00;
        end else if (clkEn) begin
            unique case (state_reg)
                CAD_ST_EXEC: begin
                    if (take && mulOp != CAD_MUL_NONE) begin
                        mulA_reg  <= opA;
                        mulB_reg  <= gpr[srcSel];
                        mulOp_reg <= mulOp;
                        state_reg <= CAD_ST_MUL2;
                    end else if (take && memOp == CAD_MEM_LPM) begin
                        lpmAddr_reg <= {gpr[`CAD_PTR_Z + 5'h01], gpr[`CAD_PTR_Z]};
                        lpmDst_reg  <= dstSel;
                        state_reg   <= CAD_ST_LPM2;
                    end
                end
                CAD_ST_MUL2: state_reg <= CAD_ST_EXEC;
                CAD_ST_LPM2: state_reg <= CAD_ST_EXEC;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // register file write-back; later writes in this block take priority
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= 8'h00;
            end
        end else if (clkEn) begin
            if (ptrWe) begin
                gpr[ptrIdx]         <= ptrNew[7:0];
                gpr[ptrIdx + 5'h01] <= ptrNew[15:8];
            end
            if (take && mulOp == CAD_MUL_NONE && memOp == CAD_MEM_NONE && aluWe) begin
                if (aluWide) begin
                    gpr[{dstSel[4:1], 1'b0}] <= pairRes[7:0];
                    gpr[{dstSel[4:1], 1'b1}] <= pairRes[15:8];
                end else begin
                    gpr[dstSel] <= aluRes;
                end
            end
            if (take && (memOp == CAD_MEM_LOAD || memOp == CAD_MEM_IN)) begin
                if (dataWide) begin
                    gpr[{dstSel[4:1], 1'b0}] <= dataRdData[7:0];
                    gpr[{dstSel[4:1], 1'b1}] <= dataRdData[15:8];
                end else begin
                    gpr[dstSel] <= dataRdData[7:0];
                end
            end
            if (state_reg == CAD_ST_MUL2) begin
                gpr[`CAD_PROD_LO] <= mulRes[7:0];
                gpr[`CAD_PROD_HI] <= mulRes[15:8];
            end
            if (state_reg == CAD_ST_LPM2) begin
                gpr[lpmDst_reg] <= lpmAddr_reg[0] ? progRdData[15:8] : progRdData[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // condition flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= `CAD_FLAGS_RESET;
        end else if (clkEn) begin
            if (state_reg == CAD_ST_MUL2) begin
                // carry comes from the unshifted product
                flags_reg[`CAD_FLAG_C] <= mulProd[15];
                flags_reg[`CAD_FLAG_Z] <= (mulRes == 16'h0000);
            end else if (take && mulOp == CAD_MUL_NONE && memOp == CAD_MEM_NONE) begin
                flags_reg <= flags_next;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !clkEn);

    sequence s_mul_start;
        take && mulOp != CAD_MUL_NONE;
    endsequence
    sequence s_mul_finish;
        busy ##1 !busy;
    endsequence

    a_fetch_starts_zero: assert property ($past(rst) && !rst |-> progAddr == `CAD_RESET_PC)
        else $error("fetch did not start at program address zero");
    a_prefetch_advance: assert property (!busy && !pcLoad |=> pc_reg == $past(pc_reg) + 16'h0001)
        else $error("prefetch did not advance while executing");
    a_mul_two_cycles: assert property (s_mul_start |=> s_mul_finish)
        else $error("multiply did not take exactly two cycles");
    a_mul_product_out: assert property (state_reg == CAD_ST_MUL2 |=> {gpr[1], gpr[0]} == $past(mulRes))
        else $error("multiply product not written to result pair");
    a_alu_single_cycle: assert property (take && aluOp == CAD_ALU_AND && memOp == CAD_MEM_NONE &&
                                         mulOp == CAD_MUL_NONE |=> gpr[$past(dstSel)] == $past(opA & opB))
        else $error("logic result not written back in one cycle");
    a_flag_zero_set: assert property (take && aluOp == CAD_ALU_EOR && memOp == CAD_MEM_NONE &&
                                      mulOp == CAD_MUL_NONE && opA == opB |=> flags_reg[`CAD_FLAG_Z])
        else $error("zero flag not set after zero result");
    a_region_io_low: assert property (dataRdEn && dataAddr <= `CAD_IO_TOP |-> dataRegion == CAD_RG_IO)
        else $error("low port address decoded outside port region");
    a_region_extended: assert property ((dataRdEn || dataWrEn) && dataAddr >= `CAD_EXTIO_LO &&
                                        dataAddr <= `CAD_EXTIO_HI |-> dataRegion == CAD_RG_EXTIO)
        else $error("extended port region decoded wrongly");
    a_region_nvm: assert property ((dataRdEn || dataWrEn) && dataAddr >= `CAD_NVM_LO &&
                                   dataAddr < `CAD_MEM_LO |-> dataRegion == CAD_RG_NVM)
        else $error("nonvolatile region decoded wrongly");
    a_region_flash: assert property ((dataRdEn || dataWrEn) && dataAddr >= `CAD_FLASH_LO |->
                                     dataRegion == CAD_RG_FLASH)
        else $error("flash window decoded wrongly");
    a_bit_op_low: assert property (dataBitEn |-> dataAddr <= `CAD_IOBIT_TOP)
        else $error("bit operation issued above lowest 32 addresses");
    a_lpm_code_addr: assert property (take && memOp == CAD_MEM_LPM |=>
                                      progAddr == {1'b0, $past(gpr[31]), $past(gpr[30][7:1])} && busy)
        else $error("program memory load used wrong code address");

endmodule : cad_core

// >>> verif/cad_mem_model.sv
`timescale 1ns/1ps
module cad_mem_model (
    // clock
    input  wire logic        core_clk,
    // program side
    input  wire logic [15:0] progAddr,
    output logic [15:0]      progRdData,
    // data side
    input  wire logic [15:0] dataAddr,
    input  wire logic        dataRdEn,
    input  wire logic        dataWrEn,
    input  wire logic [15:0] dataWrData,
    output logic [15:0]      dataRdData
);
    logic [7:0] memArr [256];
    initial foreach (memArr[i]) memArr[i] = 8'(i) ^ 8'hC3;
    assign progRdData = progAddr ^ 16'h5A3C;
    // idle read bus inverted so a stale value never passes
    assign dataRdData = dataRdEn ? {8'h00, memArr[dataAddr[7:0]]} : ~{8'h00, memArr[dataAddr[7:0]]};
    always_ff @(posedge core_clk) begin
        if (dataWrEn) memArr[dataAddr[7:0]] <= dataWrData[7:0];
    end
endmodule : cad_mem_model

// >>> verif/cad_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module cpu_alu_datapath_memmap_mul_tb_top;
    import cad_pkg::*;
    logic core_clk = 0, rst = 1, clkEn = 1, pcLoad = 0, opValid = 0, useImm = 0, useDirect = 0, wideAccess = 0;
    logic [15:0] pcTarget = 16'h0000, directAddr = 16'h0000, progAddr, progRdData, instrWord, dataAddr, dataWrData, dataRdData;
    logic [7:0] immData = 8'h00, flags;
    logic [4:0] dstSel = 5'h00, srcSel = 5'h00;
    logic [5:0] ptrDisp = 6'h00, ioAddr = 6'h00;
    logic [2:0] bitIdx = 3'h0;
    logic instrValid, dataRdEn, dataWrEn, dataWide, dataBitEn, dataBitVal, busy, skipNext, ioRefused;
    cad_aluop_t aluOp = CAD_ALU_NONE;
    cad_mulop_t mulOp = CAD_MUL_NONE;
    cad_memop_t memOp = CAD_MEM_NONE;
    cad_ptr_t ptrSel = CAD_PTR_Z;
    cad_ptrmode_t ptrMode = CAD_PM_PLAIN;
    cad_region_t dataRegion;
    int errors = 0, n_compared = 0;
    logic [15:0] regAddr [8] = '{16'h003F, 16'h0040, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800, 16'h7FFF, 16'h8000};
    cad_region_t regExp [8] = '{CAD_RG_IO, CAD_RG_EXTIO, CAD_RG_EXTIO, CAD_RG_NVM, CAD_RG_NVM, CAD_RG_SRAM,
                                CAD_RG_SRAM, CAD_RG_FLASH};
    cad_mulop_t mulTab [6] = '{CAD_MUL_UU, CAD_MUL_SS, CAD_MUL_SU, CAD_MUL_FUU, CAD_MUL_FSS, CAD_MUL_FSU};
    logic [15:0] mulExp [6] = '{16'h01FE, 16'hFFFE, 16'hFFFE, 16'h03FC, 16'hFFFC, 16'hFFFC};
    cad_core cad_core_i (.*);
    cad_mem_model cad_mem_model_i (.*);
    always #20 core_clk = ~core_clk;
    //////////////////////////////////////////////////////////////////////////
    task step; @(posedge core_clk); @(negedge core_clk); endtask : step
    task clear;
        opValid = 1'b1;
        aluOp = CAD_ALU_NONE;
        mulOp = CAD_MUL_NONE;
        memOp = CAD_MEM_NONE;
        useImm = 1'b0;
        useDirect = 1'b0;
    endtask : clear
    task ldi(input logic [4:0] r, input logic [7:0] v);
        clear();
        aluOp = CAD_ALU_MOV;
        useImm = 1'b1;
        dstSel = r;
        immData = v;
        step();
    endtask : ldi
    // store shows {R[r|1], R[r]} on the write bus
    task store_chk(input logic [4:0] r, input logic [15:0] exp);
        clear();
        memOp = CAD_MEM_STORE;
        useDirect = 1'b1;
        directAddr = 16'h1800;
        dstSel = r;
        #1 `CHK(dataWrData, exp)
        `CHK(dataWrEn, 1'b1)
        step();
    endtask : store_chk
    task t_fetch;
        `CHK(progAddr, 16'h0000)
        step();
        `CHK(instrWord, 16'h5A3C)
        `CHK(progAddr, 16'h0001)
    endtask : t_fetch
    task t_add;
        ldi(5'h02, 8'hFF);
        ldi(5'h03, 8'h01);
        clear();
        aluOp = CAD_ALU_ADD;
        dstSel = 5'h02;
        srcSel = 5'h03;
        step();
        `CHK(flags, 8'h23)
        store_chk(5'h02, 16'h0100);
    endtask : t_add
    task t_mul;
        ldi(5'h10, 8'hFF);
        ldi(5'h11, 8'h02);
        for (int i = 0; i < 6; i++) begin
            clear();
            mulOp = mulTab[i];
            dstSel = 5'h10;
            srcSel = 5'h11;
            step();
            opValid = 1'b0;
            `CHK(busy, 1'b1)
            step();
            `CHK(busy, 1'b0)
            store_chk(5'h00, mulExp[i]);
        end
    endtask : t_mul
    task t_region;
        for (int i = 0; i < 8; i++) begin
            clear();
            memOp = CAD_MEM_LOAD;
            useDirect = 1'b1;
            directAddr = regAddr[i];
            dstSel = 5'h05;
            #1 `CHK(dataRegion, regExp[i])
            step();
        end
    endtask : t_region
    task t_bit;
        clear();
        memOp = CAD_MEM_BSET;
        ioAddr = 6'h1F;
        #1 `CHK({dataBitEn, dataBitVal, dataAddr}, {2'h3, 16'h001F})
        step();
        ioAddr = 6'h20;
        #1 `CHK({ioRefused, dataBitEn}, 2'h2)
        step();
    endtask : t_bit
    task t_misc;
        ldi(5'h06, 8'h3C);
        ldi(5'h07, 8'h3C);
        clear();
        aluOp = CAD_ALU_EOR;
        dstSel = 5'h06;
        srcSel = 5'h07;
        step();
        `CHK(flags[2:1], 2'h1)
        clear();
        aluOp = CAD_ALU_AND;
        dstSel = 5'h07;
        useImm = 1'b1;
        immData = 8'h0F;
        step();
        store_chk(5'h07, 16'h0C0C);
        ldi(5'h1E, 8'h07);
        ldi(5'h1F, 8'h00);
        clear();
        memOp = CAD_MEM_LPM;
        dstSel = 5'h08;
        step();
        opValid = 1'b0;
        `CHK({busy, progAddr}, {1'b1, 16'h0003})
        step();
        store_chk(5'h08, 16'h005A);
        clear();
        memOp = CAD_MEM_SKIPSET;
        ioAddr = 6'h05;
        bitIdx = 3'h1;
        #1 `CHK({dataRdEn, skipNext}, 2'h3)
        bitIdx = 3'h0;
        #1 `CHK(skipNext, 1'b0)
        step();
        clear();
        memOp = CAD_MEM_STORE;
        useDirect = 1'b1;
        directAddr = 16'h1800;
        dstSel = 5'h10;
        wideAccess = 1'b1;
        #1 `CHK({dataWide, dataWrData}, {1'b1, 16'h02FF})
        step();
        wideAccess = 1'b0;
        clear();
        opValid = 1'b0;
        pcLoad = 1'b1;
        pcTarget = 16'h0100;
        step();
        pcLoad = 1'b0;
        `CHK({instrValid, progAddr}, {1'b0, 16'h0100})
        step();
        `CHK({instrValid, progAddr}, {1'b1, 16'h0101})
    endtask : t_misc
    task wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        t_fetch();
        t_add();
        t_mul();
        t_region();
        t_bit();
        t_misc();
        wrap_up();
    end
    initial begin
        #200000 errors++;
        wrap_up();
    end
endmodule : cpu_alu_datapath_memmap_mul_tb_top
